// [core/sspc_pkg.sv]
// constants for the serial setup and protection control block
package sspc_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam logic [15:0] INIT_RESET = 16'h0000;
  // extended setup word fields
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int VSD_MASK_BIT = 5;
  localparam int ISD_MASK_BIT = 6;
  localparam int TSD_MASK_BIT = 7;
  localparam int RMASK_C_BIT = 8;
  localparam int RMASK_B_BIT = 9;
  localparam int RMASK_A_BIT = 10;
  localparam int PREW_LSB = 11;
  localparam int PREW_MSB = 12;
  localparam int WDOG_BIT = 14;
  // initial setup word fields
  localparam int MSEL_LSB = 0;
  localparam int MSEL_MSB = 2;
  localparam int BLANK_LSB = 3;
  localparam int BLANK_MSB = 6;
  localparam int CONV_A_OFF_BIT = 7;
  localparam int CONV_B_OFF_BIT = 8;
  localparam int CONV_C_OFF_BIT = 9;
  localparam int GAIN_AB_BIT = 10;
  // shutdown source select codes
  localparam logic [3:0] SEL_CONV_A = 4'h0;
  localparam logic [3:0] SEL_CONV_B = 4'h1;
  localparam logic [3:0] SEL_CONV_C = 4'h2;
  localparam logic [3:0] SEL_OVERV = 4'h4;
  localparam logic [3:0] SEL_UNDERV = 4'h5;
  localparam logic [3:0] SEL_MOTOR = 4'h6;
  localparam logic [3:0] SEL_THERM = 4'h8;
  localparam logic [3:0] SEL_VERS = 4'h9;
  localparam logic [3:0] SEL_FILT_MAX = 4'h7;
  // dead-zone filter length in clocks
  localparam int FILT_CYC = 4;
  // start count of converters A and C, in clocks; converter B starts 7 clocks before them
  localparam int START_LEAD = 8;
  // identification code shown on the monitor pin, value arbitrary
  localparam logic [3:0] ID_CODE = 4'h5;
endpackage : sspc_pkg

// [core/sspc_top.sv]
// serial setup, shutdown monitor and protection control
`timescale 1ns/10ps
// Behaviour
// RL1: step data latched only while sleep high; setup latches while sleep low
// RL2: after reset release, sleep high selects step-data write mode
// RL3: sleep high-low-high clears latched motor data to zero
// RL4: 16-bit words routed by clock, data, strobe and sleep levels
// RL5: sleep low: data low at strobe to initial, high to extended
// RL6: extended write only with sleep low and setup select high
// RL7: power-on reset clears initial and extended setup words
// RL8: initial setup sets pairing, blanking, converter on/off, gain
// RL9: host keeps test and unused setup bits zero
// RL10: extended bits 3:0 choose shutdown cause on monitor pin
// RL11: codes 0000 to 0111 show dead-zone filtered signal
// RL12: select field may instead show identification code
// RL13: selected shutdown signals release on sleep rising edge
// RL14: bits 7,6,5 disable thermal, motor overcurrent, converter voltage shutdown
// RL15: bits 10,9,8 mask reset per converter; it restarts on sleep rise
// RL16: bits 12:11 set prewarning threshold, 11 analog mode
// RL17: bit 14 enables oscillator watchdogs; all bits default zero
// RL18: open oscillator pin shuts down; grounded at start never starts
// RL19: converter B starts before converters A and C
// RL20: reset output open drain, low while reset asserted
// RL21: warning and monitor outputs are open drain like reset
// RL22: current compare flags output control at set current
// RL23: shift on serial clock rise, bit 0 first, latch at strobe
// RL24: enabled unmasked shutdown asserts reset and stops converters
module sspc_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_strobe,
  input  wire logic        sleep,
  input  wire logic        thermal_shutdown,
  input  wire logic        motor_overcurrent_shutdown,
  input  wire logic [2:0]  converter_overvolt,
  input  wire logic [2:0]  converter_undervolt,
  input  wire logic        thermal_prewarn,
  input  wire logic        osc_fault,
  input  wire logic        current_compare,
  output logic [15:0]      step_data,
  output logic [15:0]      init_setup,
  output logic [2:0]       motor_pairing,
  output logic [3:0]       blanking_time,
  output logic             dc_gain_ab,
  output logic [1:0]       prewarn_level,
  output logic             analog_temp_mode,
  output logic             osc_watchdog_en,
  output logic [2:0]       conv_run,
  output logic             current_reached,
  output logic             reset_out_o,
  output logic             reset_out_oe_n,
  output logic             temp_warn_out_o,
  output logic             temp_warn_out_oe_n,
  output logic             monitor_pin_o,
  output logic             monitor_pin_oe_n
);
  typedef struct packed {
    logic [1:0]  sclk_s;
    logic [1:0]  sdat_s;
    logic [1:0]  sstb_s;
    logic [1:0]  slp_s;
    logic        sclk_p;
    logic        sstb_p;
    logic        slp_p;
    logic [15:0] shift;
    logic [15:0] step;
    logic [15:0] init;
    logic [15:0] ext;
    logic [1:0]  slp_hist;
    logic [2:0]  latched_sd;
    logic [2:0]  conv_off;
    logic        started;
    logic [3:0]  lead_cnt;
    logic [2:0]  filt_cnt;
    logic        filt_q;
    logic        mon_q;
    logic        rst_q;
    logic        warn_q;
    logic        cmp_q;
    logic        ext_sd;
  } sspc_state_s;

  // registered state and its next value
  sspc_state_s s_q;
  sspc_state_s s_d;

  function automatic logic sel_raw(input logic [3:0] sel, input logic [2:0] ov, input logic [2:0] uv,
                                   input logic mot, input logic th);
    case (sel)
      sspc_pkg::SEL_CONV_A: sel_raw = ov[0] | uv[0]; // [RL10]
      sspc_pkg::SEL_CONV_B: sel_raw = ov[1] | uv[1];
      sspc_pkg::SEL_CONV_C: sel_raw = ov[2] | uv[2];
      sspc_pkg::SEL_OVERV:  sel_raw = |ov;
      sspc_pkg::SEL_UNDERV: sel_raw = |uv;
      sspc_pkg::SEL_MOTOR:  sel_raw = mot;
      sspc_pkg::SEL_THERM:  sel_raw = th;
      default:              sel_raw = 1'b0;
    endcase
  endfunction : sel_raw

  // one-cycle pulse on a low-to-high step of a synchronised level
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur & ~prev;
  endfunction : rise_of

  // a converter runs when its start slot is open, setup leaves it on and no shutdown holds it
  function automatic logic conv_enable(input logic up, input logic setup_off, input logic held_off);
    conv_enable = up & ~setup_off & ~held_off;
  endfunction : conv_enable

  logic [3:0] sel;
  logic       slp_rise;
  logic       clk_rise;
  logic       stb_rise;
  logic [2:0] conv_sd;
  logic       vsd_en;
  logic       isd_en;
  logic       tsd_en;
  logic       wdog_sd;
  logic       global_sd;
  logic       raw;
  logic [2:0] rmask;

  always_comb begin
    s_d = s_q;
    sel = s_q.ext[sspc_pkg::SEL_MSB:sspc_pkg::SEL_LSB];
    rmask = {s_q.ext[sspc_pkg::RMASK_C_BIT], s_q.ext[sspc_pkg::RMASK_B_BIT], s_q.ext[sspc_pkg::RMASK_A_BIT]};
    vsd_en = ~s_q.ext[sspc_pkg::VSD_MASK_BIT]; // [RL14]
    isd_en = ~s_q.ext[sspc_pkg::ISD_MASK_BIT];
    tsd_en = ~s_q.ext[sspc_pkg::TSD_MASK_BIT];
    s_d.sclk_s = {s_q.sclk_s[0], ser_clk};
    s_d.sdat_s = {s_q.sdat_s[0], ser_data};
    s_d.sstb_s = {s_q.sstb_s[0], ser_strobe};
    s_d.slp_s  = {s_q.slp_s[0], sleep};
    s_d.sclk_p = s_q.sclk_s[1];
    s_d.sstb_p = s_q.sstb_s[1];
    s_d.slp_p  = s_q.slp_s[1];
    clk_rise = rise_of(s_q.sclk_s[1], s_q.sclk_p);
    stb_rise = rise_of(s_q.sstb_s[1], s_q.sstb_p);
    slp_rise = rise_of(s_q.slp_s[1], s_q.slp_p);
    if (clk_rise) begin
      s_d.shift = {s_q.sdat_s[1], s_q.shift[15:1]}; // [RL23]
    end
    if (stb_rise) begin
      if (s_q.slp_s[1]) begin
        if (s_q.started) begin
          s_d.step = s_q.shift; // [RL1] [RL2] [RL4]
        end
      end else if (s_q.sdat_s[1]) begin
        s_d.ext = s_q.shift; // [RL5] [RL6]
      end else begin
        s_d.init = s_q.shift; // [RL5] [RL8]
      end
    end
    if (s_q.slp_s[1] != s_q.slp_p) begin
      s_d.slp_hist = {s_q.slp_hist[0], s_q.slp_s[1]};
      if (slp_rise && s_q.slp_hist == 2'b10) begin
        s_d.step = '0; // [RL3]
      end
    end
    conv_sd = (converter_overvolt | converter_undervolt) & {3{vsd_en}};
    // oscillator watchdog only shuts down once enabled by the extended word
    wdog_sd = osc_fault & s_q.ext[sspc_pkg::WDOG_BIT]; // [RL17] [RL18]
    global_sd = (motor_overcurrent_shutdown & isd_en) | (thermal_shutdown & tsd_en) | wdog_sd;
    s_d.ext_sd = global_sd | (|(conv_sd & ~rmask));
    s_d.latched_sd = s_q.latched_sd | conv_sd;
    if (slp_rise) begin
      s_d.latched_sd = conv_sd; // [RL13] [RL15]
      s_d.ext_sd = global_sd;
    end
    if (s_q.ext_sd) begin
      s_d.conv_off = 3'b111; // [RL24]
    end else begin
      s_d.conv_off = s_q.latched_sd & rmask; // [RL15]
    end
    s_d.rst_q = s_q.ext_sd | (|(s_q.latched_sd & ~rmask)) | ~s_q.started; // [RL24]
    if (!s_q.started && !osc_fault) begin
      s_d.started = 1'b1; // [RL18]
    end
    if (s_q.started && s_q.lead_cnt != 4'(sspc_pkg::START_LEAD)) begin
      s_d.lead_cnt = s_q.lead_cnt + 4'h1; // [RL19]
    end
    raw = sel_raw(sel, converter_overvolt, converter_undervolt, motor_overcurrent_shutdown, thermal_shutdown);
    if (raw != s_q.filt_q) begin
      s_d.filt_cnt = s_q.filt_cnt + 3'h1;
      if (s_q.filt_cnt == 3'(sspc_pkg::FILT_CYC - 1)) begin
        s_d.filt_q = raw;
        s_d.filt_cnt = '0;
      end
    end else begin
      s_d.filt_cnt = '0;
    end
    if (sel <= sspc_pkg::SEL_FILT_MAX) begin
      s_d.mon_q = s_q.filt_q; // [RL11]
    end else if (sel == sspc_pkg::SEL_THERM) begin
      s_d.mon_q = raw;
    end else if (sel >= sspc_pkg::SEL_VERS) begin
      s_d.mon_q = sspc_pkg::ID_CODE[2'(sel - sspc_pkg::SEL_VERS)]; // [RL12]
    end else begin
      s_d.mon_q = 1'b0;
    end
    s_d.warn_q = thermal_prewarn; // [RL16]
    s_d.cmp_q = current_compare; // [RL22]
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.init <= sspc_pkg::INIT_RESET; // [RL7]
      s_q.ext <= sspc_pkg::EXT_RESET; // [RL7] [RL17]
    end else begin
      s_q <= s_d;
    end
  end

  logic conv_b_up;
  logic conv_ac_up;
  logic run_a;
  logic run_b;
  logic run_c;
  assign conv_b_up  = s_q.started & ~s_q.rst_q;
  assign conv_ac_up = conv_b_up & (s_q.lead_cnt == 4'(sspc_pkg::START_LEAD));
  assign run_a = conv_enable(conv_ac_up, s_q.init[sspc_pkg::CONV_A_OFF_BIT], s_q.conv_off[0]);
  assign run_b = conv_enable(conv_b_up, s_q.init[sspc_pkg::CONV_B_OFF_BIT], s_q.conv_off[1]);
  assign run_c = conv_enable(conv_ac_up, s_q.init[sspc_pkg::CONV_C_OFF_BIT], s_q.conv_off[2]);
  assign conv_run = {run_c, run_b, run_a}; // [RL19] [RL15]
  assign step_data = s_q.step;
  assign init_setup = s_q.init;
  assign motor_pairing = s_q.init[sspc_pkg::MSEL_MSB:sspc_pkg::MSEL_LSB];
  assign blanking_time = s_q.init[sspc_pkg::BLANK_MSB:sspc_pkg::BLANK_LSB];
  assign dc_gain_ab = s_q.init[sspc_pkg::GAIN_AB_BIT];
  assign prewarn_level = s_q.ext[sspc_pkg::PREW_MSB:sspc_pkg::PREW_LSB]; // [RL16]
  assign analog_temp_mode = &s_q.ext[sspc_pkg::PREW_MSB:sspc_pkg::PREW_LSB];
  assign osc_watchdog_en = s_q.ext[sspc_pkg::WDOG_BIT]; // [RL17]
  assign current_reached = s_q.cmp_q;
  assign reset_out_o = 1'b0;
  assign reset_out_oe_n = ~s_q.rst_q; // [RL20]
  assign temp_warn_out_o = 1'b0;
  assign temp_warn_out_oe_n = ~(s_q.warn_q & ~analog_temp_mode); // [RL21]
  assign monitor_pin_o = 1'b0;
  assign monitor_pin_oe_n = ~s_q.mon_q; // [RL21]
endmodule : sspc_top

// [sim/sspc_host.sv]
// host model driving the serial pins of the setup port
`timescale 1ns/10ps
module sspc_host (
  input  wire logic mclk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_strobe
);
  // pins are pulled down, so idle level is low
  initial begin
    {ser_clk, ser_data, ser_strobe} = 3'h0;
  end

  // every level held h clocks, h at least 3
  task automatic send(input logic [15:0] w, input logic sel, input int h);
    for (int i = 0; i < 16; i++) begin
      ser_data <= w[i];
      repeat (h) @(posedge mclk);
      ser_clk <= 1'b1;
      repeat (h) @(posedge mclk);
      ser_clk <= 1'b0;
    end
    ser_data <= sel;
    repeat (h) @(posedge mclk);
    ser_strobe <= 1'b1;
    repeat (h) @(posedge mclk);
    {ser_strobe, ser_data} <= 2'h0;
    repeat (h) @(posedge mclk);
  endtask : send
endmodule : sspc_host

// [sim/sspc_monitor.sv]
// port checker of the setup and protection block
`timescale 1ns/10ps
module sspc_monitor (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        sleep,
  input wire logic        ser_strobe,
  input wire logic        current_compare,
  input wire logic [15:0] step_data,
  input wire logic [15:0] init_setup,
  input wire logic [2:0]  motor_pairing,
  input wire logic        analog_temp_mode,
  input wire logic        osc_watchdog_en,
  input wire logic [2:0]  conv_run,
  input wire logic        current_reached,
  input wire logic        reset_out_o,
  input wire logic        temp_warn_out_o,
  input wire logic        temp_warn_out_oe_n,
  input wire logic        monitor_pin_o
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  AST_OPEN_DRAIN: assert property (!(reset_out_o | temp_warn_out_o | monitor_pin_o)) else $error("pin driven high");
  AST_CUR: assert property (1'b1 |=> current_reached == $past(current_compare)) else $error("bad current flag");
  AST_B_FIRST: assert property ($rose(conv_run[0]) || $rose(conv_run[2]) |-> $past(conv_run[1])) else $error("B late");
  AST_CONV_OFF: assert property ((conv_run & init_setup[9:7]) == 3'h0) else $error("converter not off");
  AST_FIELDS: assert property (motor_pairing == init_setup[2:0]) else $error("pairing field");
  AST_STROBE_HOLD: assert property (!ser_strobe [*6] |=> $stable({init_setup, osc_watchdog_en})) else $error("no strobe");
  AST_SLEEP_HOLD: assert property (!sleep [*6] |=> $stable(step_data)) else $error("step data moved");
  AST_ANALOG: assert property (analog_temp_mode |-> temp_warn_out_oe_n) else $error("warn in analog mode");
endmodule : sspc_monitor

bind sspc_top sspc_monitor sspc_monitor_inst (.*);

// [sim/sspc_top_tb.sv]
// self-checking bench of the setup and protection block
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module sspc_top_tb;
  logic mclk, nrst, sleep, ser_clk, ser_data, ser_strobe, thermal_shutdown, motor_overcurrent_shutdown, osc_fault;
  logic thermal_prewarn, current_compare, dc_gain_ab, analog_temp_mode, osc_watchdog_en, current_reached;
  logic reset_out_o, reset_out_oe_n, temp_warn_out_o, temp_warn_out_oe_n, monitor_pin_o, monitor_pin_oe_n;
  logic [15:0] step_data, init_setup, es, ei, ee, w;
  logic [2:0]  converter_overvolt, converter_undervolt, motor_pairing, conv_run;
  logic [3:0]  blanking_time;
  logic [1:0]  prewarn_level;
  logic [35:0] last, en, nq, q[$];
  logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  wire [35:0]  snap = {step_data, init_setup, prewarn_level, analog_temp_mode, osc_watchdog_en};
  sspc_top sspc_top_inst (.*);
  sspc_host sspc_host_inst (.*);
  always #5 mclk = ~mclk;

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // a write that leaves the visible words unchanged produces no change to wait for
  task automatic note();
    logic [35:0] v;
    v = {es, ei, ee[12:11], &ee[12:11], ee[14]};
    if (v !== nq) begin
      q.push_back(v);
      nq = v;
    end
  endtask : note

  // k: 0 step, 1 initial, 2 extended
  task automatic wrt(input logic [1:0] k, input logic [15:0] v);
    if (k == 2'h0) es = v;
    else if (k == 2'h1) ei = v;
    else ee = v;
    note();
    sspc_host_inst.send(v, k[1], 3 + 2 * v[0]);
  endtask : wrt

  always @(posedge mclk) begin
    cycles++;
    current_compare <= 1'($urandom);
    thermal_prewarn <= 1'($urandom);
    if (cycles == 12000) begin
      num_errors++;
      conclude();
    end
  end

  // a change of the latched words consumes the oldest note
  always @(posedge mclk) begin
    last <= snap;
    if (nrst === 1'b1 && snap !== last) begin
      en = (q.size() == 0) ? last : q.pop_front();
      `CHK("latched_words", en, snap)
    end
  end

  initial begin
    mclk = 1'b0;
    {nrst, sleep, thermal_shutdown, motor_overcurrent_shutdown, osc_fault, thermal_prewarn, current_compare} = '0;
    {converter_overvolt, converter_undervolt, es, ei, ee, nq} = '0;
    void'($urandom(32'h6f86031e));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 100 && reset_out_oe_n !== 1'b1; i++) @(posedge mclk);
    `CHK("reset_release", 1'b1, reset_out_oe_n)
    for (int i = 0; i < 8; i++) begin
      wrt(2'h2, {1'b0, i[0], 1'b0, i[1:0], 3'h0, i[2:0], 1'b0, codes[i]});
      `CHK("monitor_pin", (codes[i] == sspc_pkg::SEL_VERS) ? ~sspc_pkg::ID_CODE[0] : 1'b1, monitor_pin_oe_n)
    end
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom) & 16'h047B;
      wrt(2'h1, w ^ 16'(w == ei));
    end
    wrt(2'h2, 16'h0400);
    converter_undervolt <= 3'h1;
    repeat (12) @(posedge mclk);
    converter_undervolt <= 3'h0;
    `CHK("masked_run", 3'h6, conv_run)
    `CHK("masked_reset", 1'b1, reset_out_oe_n)
    `CHK("monitor_conv_a", 1'b0, monitor_pin_oe_n)
    sleep <= 1'b1;
    repeat (20) @(posedge mclk);
    `CHK("restart", 3'h7, conv_run)
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      wrt(2'h0, w ^ 16'(w == es));
    end
    es = '0;
    note();
    sleep <= 1'b0;
    repeat (6) @(posedge mclk);
    sleep <= 1'b1;
    repeat (12) @(posedge mclk);
    `CHK("pending", 1'b1, q.size() == 0)
    thermal_shutdown <= 1'b1;
    repeat (12) @(posedge mclk);
    `CHK("tsd_reset", 1'b0, reset_out_oe_n)
    `CHK("tsd_run", 3'h0, conv_run)
    nrst <= 1'b0;
    thermal_shutdown <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("power_on_clear", 36'h0, snap)
    conclude();
  end
endmodule : sspc_top_tb
